// *** include/nwtr_consts.svh ***
`ifndef NWTR_CONSTS_SVH
`define NWTR_CONSTS_SVH
`define NWTR_A_CTRL 8'h00
`define NWTR_A_CW0 8'h04
`define NWTR_A_CW1 8'h08
`define NWTR_A_CW2 8'h0C
`define NWTR_A_SRC 8'h10
`define NWTR_A_DST 8'h14
`define NWTR_A_AEND 8'h18
`define NWTR_A_IND 8'h1C
`define NWTR_A_STAT 8'h20
`define NWTR_C_GO 0
`define NWTR_C_EXEC 1
`define NWTR_C_SEND 2
`define NWTR_C_IND 3
`define NWTR_S_EN 0
`define NWTR_S_XERR 1
`define NWTR_S_IERR 2
`define NWTR_S_BUSY 3
`define NWTR_CW1_TYPE 15
`define NWTR_CW1_LVL0 14
`define NWTR_NODE_MAX_A 8'h7E
`define NWTR_NODE_MAX_B 8'h3E
`define NWTR_LIM_DEF 8'h00
`define NWTR_LIM_NONE 8'hFF
`define NWTR_DM_LAST 16'h1FFF
`define NWTR_CLK_NS 25
`define NWTR_TICK_NS 100000000
`define NWTR_TOUT_NS 1000000000
`define NWTR_DEFLIM_NS 2000000000
`define NWTR_RESP_OK 2'h0
`define NWTR_RESP_ERR 2'h2
`endif

// *** include/nwtr_pkg.sv ***
package nwtr_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_WAIT, ST_DONE} nwtr_state_e;
   typedef struct packed {
      logic send;
      logic net_b;
      logic level0;
      logic [3:0] retries;
      logic [7:0] param;
      logic [7:0] node;
      logic [7:0] port;
      logic [15:0] count;
      logic [15:0] src;
      logic [15:0] dst;
   } nwtr_cmd_s;
endpackage

// *** design/nwtr_top.sv ***
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`include "nwtr_consts.svh"
// Summary of operation
// - no action while execution condition is false
// - received words stored from destination word onward
// - control word one bit 15 picks network
// - second network limit in tenths; zero two seconds, FF none
// - node above limit raises instruction error
// - receive overrunning area raises instruction error
// - send overrunning area raises instruction error
// - bad indirect operand raises instruction error
// - missing network unit raises instruction error
// - finished only after response is acknowledged
// - enable flag rises at next end-of-program
// - enable low during operation; requester waits
// - error flag shows last result until next
// - timeout or data error means failure
// - send transmits source words to destination
module nwtr_top #(
   parameter int unsigned TICK_CYC = `NWTR_TICK_NS / `NWTR_CLK_NS,
   parameter logic [15:0] DM_LAST = `NWTR_DM_LAST
) (
   input logic aclk,
   input logic aresetn,
   input logic [7:0] awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   input logic [7:0] araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready,
   input logic unit_present,
   input logic eop_pulse,
   output logic cmd_valid,
   output nwtr_pkg::nwtr_cmd_s cmd,
   input logic cmd_ready,
   input logic rx_valid,
   input logic [15:0] rx_data,
   input logic resp_valid,
   input logic resp_err,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_data,
   output logic transfer_enable_flag,
   output logic transfer_error_flag,
   output logic instruction_error_flag
);
   function automatic logic [15:0] merge(logic [15:0] old, logic [31:0] nw, logic [3:0] be);
      merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction
   function automatic logic over_end(logic [15:0] base, logic [15:0] cnt, logic [15:0] last);
      logic [16:0] endw;
      endw = {1'b0, base} + {1'b0, cnt};
      over_end = (cnt != 16'h0000) && ((endw - 17'h00001) > {1'b0, last});
   endfunction
   function automatic logic is_bcd(logic [15:0] v);
      is_bcd = (v[15:12] < 4'hA) && (v[11:8] < 4'hA) && (v[7:4] < 4'hA) && (v[3:0] < 4'hA);
   endfunction
   function automatic logic [15:0] bcd_val(logic [15:0] v);
      bcd_val = 16'(v[15:12]) * 16'h03E8 + 16'(v[11:8]) * 16'h0064
         + 16'(v[7:4]) * 16'h000A + 16'(v[3:0]);
   endfunction

   localparam logic [7:0] TOUT_TICKS = 8'(`NWTR_TOUT_NS / `NWTR_TICK_NS);
   localparam logic [7:0] DEFLIM_TICKS = 8'(`NWTR_DEFLIM_NS / `NWTR_TICK_NS);

   nwtr_pkg::nwtr_state_e st_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic exec_q, send_q, ind_en_q;
   logic [15:0] cw0_q, cw1_q, cw2_q, src_q, dst_q, aend_q, ind_q;
   logic en_q, xerr_q, ierr_q;
   logic sync1_q, sync2_q, sync3_q, unit_ok_q;
   logic cmd_valid_q;
   nwtr_pkg::nwtr_cmd_s cmd_q;
   logic [31:0] cyc_q;
   logic [7:0] ticks_q, limit_q;
   logic [15:0] rx_idx_q;
   logic mem_we_q;
   logic [15:0] mem_addr_q, mem_data_q;

   logic wr_fire, go, start, node_bad, area_bad, ind_bad, chk_err;
   logic timeout, fin_ok, fin_fail, rx_take, wr_map;
   logic [7:0] lim_ticks;
   logic [31:0] rd_mux;
   logic rd_map;

   assign wr_fire = !awready_q && !wready_q && !bvalid_q;
   assign go = wr_fire && (awaddr_q == `NWTR_A_CTRL) && wstrb_q[0] && wdata_q[`NWTR_C_GO];
   assign start = go && wdata_q[`NWTR_C_EXEC] && en_q && (st_q == nwtr_pkg::ST_IDLE);
   assign node_bad = cw1_q[`NWTR_CW1_TYPE] ? (cw2_q[7:0] > `NWTR_NODE_MAX_B)
      : (cw2_q[7:0] > `NWTR_NODE_MAX_A);
   assign area_bad = over_end(wdata_q[`NWTR_C_SEND] ? src_q : dst_q, cw0_q, aend_q);
   assign ind_bad = wdata_q[`NWTR_C_IND] && (!is_bcd(ind_q) || (bcd_val(ind_q) > DM_LAST));
   assign chk_err = node_bad || area_bad || ind_bad || !unit_ok_q;
   // time limit decode; one second on the first network
   assign lim_ticks = !cw1_q[`NWTR_CW1_TYPE] ? TOUT_TICKS
      : (cw1_q[7:0] == `NWTR_LIM_DEF) ? DEFLIM_TICKS
      : (cw1_q[7:0] == `NWTR_LIM_NONE) ? 8'h00 : cw1_q[7:0];
   assign timeout = (st_q == nwtr_pkg::ST_WAIT) && (limit_q != 8'h00) && (ticks_q == limit_q);
   assign fin_ok = (st_q == nwtr_pkg::ST_WAIT) && resp_valid && !resp_err && !timeout;
   assign fin_fail = (st_q == nwtr_pkg::ST_WAIT) && ((resp_valid && resp_err) || timeout);
   assign rx_take = (st_q == nwtr_pkg::ST_WAIT) && rx_valid && !cmd_q.send
      && (rx_idx_q < cmd_q.count);
   assign wr_map = (awaddr_q <= `NWTR_A_STAT) && (awaddr_q[1:0] == 2'h0);

   always_comb begin
      rd_map = 1'b1;
      unique case (araddr)
         `NWTR_A_CTRL: rd_mux = {28'h0000000, ind_en_q, send_q, exec_q, 1'b0};
         `NWTR_A_CW0: rd_mux = {16'h0000, cw0_q};
         `NWTR_A_CW1: rd_mux = {16'h0000, cw1_q};
         `NWTR_A_CW2: rd_mux = {16'h0000, cw2_q};
         `NWTR_A_SRC: rd_mux = {16'h0000, src_q};
         `NWTR_A_DST: rd_mux = {16'h0000, dst_q};
         `NWTR_A_AEND: rd_mux = {16'h0000, aend_q};
         `NWTR_A_IND: rd_mux = {16'h0000, ind_q};
         `NWTR_A_STAT: rd_mux = {28'h0000000, st_q != nwtr_pkg::ST_IDLE, ierr_q, xerr_q, en_q};
         default: begin
            rd_mux = 32'h00000000;
            rd_map = 1'b0;
         end
      endcase
   end

   // write channels taken in either order, answered once both are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= `NWTR_RESP_OK;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         if (awvalid && awready_q) begin
            awaddr_q <= awaddr;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wready_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? `NWTR_RESP_OK : `NWTR_RESP_ERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `NWTR_RESP_OK;
      end else if (arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_map ? `NWTR_RESP_OK : `NWTR_RESP_ERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // control words locked while an operation runs, so the command stays coherent
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {exec_q, send_q, ind_en_q} <= 3'h0;
         {cw0_q, cw1_q, cw2_q} <= 48'h000000000000;
         {src_q, dst_q, aend_q, ind_q} <= 64'h0000000000000000;
      end else if (wr_fire && (st_q == nwtr_pkg::ST_IDLE)) begin
         unique case (awaddr_q)
            `NWTR_A_CTRL: if (wstrb_q[0]) begin
               exec_q <= wdata_q[`NWTR_C_EXEC];
               send_q <= wdata_q[`NWTR_C_SEND];
               ind_en_q <= wdata_q[`NWTR_C_IND];
            end
            `NWTR_A_CW0: cw0_q <= merge(cw0_q, wdata_q, wstrb_q);
            `NWTR_A_CW1: cw1_q <= merge(cw1_q, wdata_q, wstrb_q);
            `NWTR_A_CW2: cw2_q <= merge(cw2_q, wdata_q, wstrb_q);
            `NWTR_A_SRC: src_q <= merge(src_q, wdata_q, wstrb_q);
            `NWTR_A_DST: dst_q <= merge(dst_q, wdata_q, wstrb_q);
            `NWTR_A_AEND: aend_q <= merge(aend_q, wdata_q, wstrb_q);
            `NWTR_A_IND: ind_q <= merge(ind_q, wdata_q, wstrb_q);
            default: ;
         endcase
      end
   end

   // unit presence pin: three stages, accepted once the last two agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {sync1_q, sync2_q, sync3_q, unit_ok_q} <= 4'h0;
      end else begin
         sync1_q <= unit_present;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) begin
            unit_ok_q <= sync3_q;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= nwtr_pkg::ST_IDLE;
         cmd_valid_q <= 1'b0;
         cmd_q <= '0;
         limit_q <= 8'h00;
      end else begin
         unique case (st_q)
            nwtr_pkg::ST_IDLE: if (start && !chk_err) begin
               // command build; no command on failed check
               cmd_q <= {wdata_q[`NWTR_C_SEND], cw1_q[`NWTR_CW1_TYPE], cw1_q[`NWTR_CW1_LVL0],
                  cw1_q[11:8], cw1_q[7:0], cw2_q[7:0], cw2_q[15:8], cw0_q, src_q, dst_q};
               cmd_valid_q <= 1'b1;
               limit_q <= lim_ticks;
               st_q <= nwtr_pkg::ST_CMD;
            end
            nwtr_pkg::ST_CMD: if (cmd_ready) begin
               cmd_valid_q <= 1'b0;
               st_q <= nwtr_pkg::ST_WAIT;
            end
            nwtr_pkg::ST_WAIT: if (fin_ok || fin_fail) begin
               st_q <= nwtr_pkg::ST_DONE;
            end
            nwtr_pkg::ST_DONE: if (eop_pulse) begin
               st_q <= nwtr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || (st_q != nwtr_pkg::ST_WAIT)) begin
         cyc_q <= 32'h00000000;
         ticks_q <= 8'h00;
      end else if (cyc_q == 32'(TICK_CYC - 1)) begin
         cyc_q <= 32'h00000000;
         ticks_q <= ticks_q + 8'h01;
      end else begin
         cyc_q <= cyc_q + 32'h00000001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_idx_q <= 16'h0000;
         mem_we_q <= 1'b0;
         mem_addr_q <= 16'h0000;
         mem_data_q <= 16'h0000;
      end else begin
         mem_we_q <= rx_take;
         if (st_q == nwtr_pkg::ST_CMD) begin
            rx_idx_q <= 16'h0000;
         end else if (rx_take) begin
            mem_addr_q <= cmd_q.dst + rx_idx_q;
            mem_data_q <= rx_data;
            rx_idx_q <= rx_idx_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= 1'b1;
         xerr_q <= 1'b0;
         ierr_q <= 1'b0;
      end else begin
         // enable low until end-of-program after completion
         if (start && !chk_err) begin
            en_q <= 1'b0;
         end else if ((st_q == nwtr_pkg::ST_DONE) && eop_pulse) begin
            en_q <= 1'b1;
         end
         if (fin_fail) begin
            xerr_q <= 1'b1;
         end else if (fin_ok) begin
            xerr_q <= 1'b0;
         end
         // sticky instruction error, set beats write-one clear
         if (start && chk_err) begin
            ierr_q <= 1'b1;
         end else if (wr_fire && (awaddr_q == `NWTR_A_STAT) && wstrb_q[0]
                      && wdata_q[`NWTR_S_IERR]) begin
            ierr_q <= 1'b0;
         end
      end
   end

   assign {awready, wready, bvalid, bresp} = {awready_q, wready_q, bvalid_q, bresp_q};
   assign {arready, rvalid, rdata, rresp} = {arready_q, rvalid_q, rdata_q, rresp_q};
   assign {cmd_valid, cmd} = {cmd_valid_q, cmd_q};
   assign {mem_we, mem_addr, mem_data} = {mem_we_q, mem_addr_q, mem_data_q};
   assign {transfer_enable_flag, transfer_error_flag} = {en_q, xerr_q};
   assign instruction_error_flag = ierr_q;

   sequence s_finish;
      (fin_ok || fin_fail) ##1 (st_q == nwtr_pkg::ST_DONE);
   endsequence
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_exec_false: assert property (go && !wdata_q[`NWTR_C_EXEC] && st_q == nwtr_pkg::ST_IDLE
      |=> st_q == nwtr_pkg::ST_IDLE && !cmd_valid_q) else $error("acted without condition");
   a_rx_store: assert property (rx_take |=> mem_we_q
      && mem_addr_q == $past(cmd_q.dst) + $past(rx_idx_q) && mem_data_q == $past(rx_data))
      else $error("bad word store");
   a_node_err: assert property (start && node_bad |=> ierr_q) else $error("node not flagged");
   a_area_err: assert property (start && area_bad |=> ierr_q) else $error("area not flagged");
   a_check_quiet: assert property (start && chk_err |=> st_q == nwtr_pkg::ST_IDLE
      && $stable(en_q) && $stable(xerr_q) && !cmd_valid_q) else $error("failed check acted");
   a_en_low: assert property (st_q != nwtr_pkg::ST_IDLE |-> !en_q)
      else $error("enable high in operation");
   a_en_eop: assert property (s_finish ##0 !eop_pulse |=> !en_q)
      else $error("enable rose before end-of-program");
   a_err_result: assert property (s_finish |-> xerr_q == $past(fin_fail))
      else $error("error flag wrong");
   a_timeout: assert property (timeout |=> xerr_q && st_q == nwtr_pkg::ST_DONE)
      else $error("timeout not failed");
endmodule

// *** verif/nwtr_link_model.sv ***
module nwtr_link_model (
   input logic aclk,
   input logic aresetn,
   input logic cmd_valid,
   input nwtr_pkg::nwtr_cmd_s cmd,
   output logic cmd_ready,
   output logic rx_valid,
   output logic [15:0] rx_data,
   output logic resp_valid,
   output logic resp_err,
   input logic [1:0] mode,
   input int lag
);
   timeunit 1ns;
   timeprecision 100ps;
   nwtr_pkg::nwtr_cmd_s c;
   initial begin
      cmd_ready = 1'b0;
      rx_valid = 1'b0;
      rx_data = 16'h5A5A;
      resp_valid = 1'b0;
      resp_err = 1'b0;
      forever begin
         @(posedge aclk);
         if (aresetn && cmd_valid) begin
            cmd_ready <= 1'b1;
            @(posedge aclk);
            c = cmd;
            cmd_ready <= 1'b0;
            // mode 2: remote never answers
            if (mode != 2'h2) begin
               for (int i = 0; i < c.count && !c.send; i++) begin
                  @(posedge aclk);
                  rx_valid <= 1'b1;
                  rx_data <= 16'hA000 + i[15:0];
                  @(posedge aclk);
                  rx_valid <= 1'b0;
                  rx_data <= ~rx_data;
               end
               repeat (lag) @(posedge aclk);
               resp_valid <= 1'b1;
               resp_err <= (mode == 2'h1);
               @(posedge aclk);
               resp_valid <= 1'b0;
               resp_err <= ~resp_err;
            end
         end
      end
   end
endmodule

// *** verif/tb.sv ***
`include "nwtr_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic bvalid, arready, rvalid, unit_present, eop_pulse, cmd_valid, cmd_ready;
   logic rx_valid, resp_valid, resp_err, mem_we;
   logic transfer_enable_flag, transfer_error_flag, instruction_error_flag;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_q;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, mode, resp_q;
   logic [15:0] rx_data, mem_addr, mem_data, exp_base;
   nwtr_pkg::nwtr_cmd_s cmd, last_cmd;
   int lag, error_cnt, comparisons, wcnt, cmd_seen;
   // checks that must refuse: node, overrun, indirect, no unit
   localparam logic [15:0] TV [7][7] = '{
      '{16'h1, 16'h0000, 16'h7F, 16'h0100, 16'h1FFF, 16'h0000, 16'h3},
      '{16'h1, 16'h8000, 16'h3F, 16'h0100, 16'h1FFF, 16'h0000, 16'h3},
      '{16'h4, 16'h0000, 16'h01, 16'h1FFE, 16'h1FFF, 16'h0000, 16'h3},
      '{16'h4, 16'h0000, 16'h01, 16'h1FFE, 16'h1FFF, 16'h0000, 16'h7},
      '{16'h1, 16'h0000, 16'h01, 16'h0100, 16'h1FFF, 16'h00A5, 16'hB},
      '{16'h1, 16'h0000, 16'h01, 16'h0100, 16'h1FFF, 16'h9999, 16'hB},
      '{16'h1, 16'h0000, 16'h01, 16'h0100, 16'h1FFF, 16'h0000, 16'h3}};

   nwtr_top #(.TICK_CYC(4)) uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .unit_present, .eop_pulse, .cmd_valid, .cmd, .cmd_ready, .rx_valid,
      .rx_data, .resp_valid, .resp_err, .mem_we, .mem_addr, .mem_data, .transfer_enable_flag,
      .transfer_error_flag, .instruction_error_flag);
   nwtr_link_model link (.aclk, .aresetn, .cmd_valid, .cmd, .cmd_ready, .rx_valid, .rx_data,
      .resp_valid, .resp_err, .mode, .lag);

   always #12.5 aclk = ~aclk;

   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   always @(posedge aclk) begin
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
         cmd_seen++;
         last_cmd = cmd;
      end
      if (mem_we === 1'b1) begin
         chk(mem_addr === exp_base + wcnt[15:0] && mem_data === 16'hA000 + wcnt[15:0], "rx word");
         wcnt++;
      end
   end

   // waits as long as the slave needs; only the watchdog ends a hang
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      resp_q = bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd_q = rdata;
      resp_q = rresp;
   endtask

   task automatic setup(input logic [15:0] c0, c1, c2, base, aend, ind);
      wr(`NWTR_A_CW0, {16'h0, c0});
      wr(`NWTR_A_CW1, {16'h0, c1});
      wr(`NWTR_A_CW2, {16'h0, c2});
      wr(`NWTR_A_SRC, {16'h0, base});
      wr(`NWTR_A_DST, {16'h0, base});
      wr(`NWTR_A_AEND, {16'h0, aend});
      wr(`NWTR_A_IND, {16'h0, ind});
   endtask

   task automatic op(input logic [15:0] c0, c1, c2, base, ctl, input logic [1:0] m, int lg);
      mode <= m;
      lag <= lg;
      wcnt = 0;
      exp_base = base;
      setup(c0, c1, c2, base, 16'h1FFF, 16'h0);
      wr(`NWTR_A_CTRL, {16'h0, ctl});
   endtask

   task automatic wresp();
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (resp_valid !== 1'b1 && n < 1500);
      chk(resp_valid === 1'b1, "no response");
      repeat (3) @(posedge aclk);
   endtask

   task automatic eop(input logic e);
      @(posedge aclk);
      eop_pulse <= 1'b1;
      @(posedge aclk);
      eop_pulse <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(transfer_enable_flag === e, "enable flag");
   endtask

   task automatic s_reset();
      chk(transfer_enable_flag === 1'b1 && transfer_error_flag === 1'b0, "reset flags");
      rd(`NWTR_A_STAT);
      chk(rd_q[3:0] === 4'h1, "status at reset");
      rd(8'h24);
      chk(resp_q === `NWTR_RESP_ERR, "unmapped read");
      wr(8'h30, 32'h0);
      chk(resp_q === `NWTR_RESP_ERR, "unmapped write");
   endtask

   task automatic s_noexec();
      op(16'h2, 16'h0, 16'h0A, 16'h0100, 16'h1, 2'h0, 1);
      repeat (8) @(posedge aclk);
      chk(cmd_seen === 0 && transfer_enable_flag === 1'b1, "no exec");
   endtask

   task automatic s_recv();
      op(16'h3, 16'h4000, 16'h007E, 16'h1FFD, 16'h3, 2'h0, 2);
      repeat (4) @(posedge aclk);
      chk(transfer_enable_flag === 1'b0, "enable in op");
      wresp();
      chk(wcnt === 3 && transfer_error_flag === 1'b0 && last_cmd.node === 8'h7E, "recv");
      chk(last_cmd.count === 16'h3 && last_cmd.level0 === 1'b1, "recv cmd");
      chk(last_cmd.port === 8'h00 && last_cmd.dst === 16'h1FFD, "recv port");
      chk(transfer_enable_flag === 1'b0, "enable before eop");
      eop(1'b1);
   endtask

   task automatic s_tmo_a();
      op(16'h0, 16'h4000, 16'h05, 16'h0200, 16'h3, 2'h2, 0);
      repeat (30) @(posedge aclk);
      eop(1'b0);
      repeat (15) @(posedge aclk);
      chk(transfer_error_flag === 1'b1, "timeout error");
      eop(1'b1);
   endtask

   task automatic s_lim_ff();
      // words legal for second network
      // answer later than 255 ticks, so a finite reading of FF would time out
      op(16'h1, 16'hC3FF, 16'h3E, 16'h0300, 16'h3, 2'h0, 1100);
      repeat (95) @(posedge aclk);
      eop(1'b0);
      wresp();
      chk(transfer_error_flag === 1'b0 && last_cmd.net_b === 1'b1 && wcnt === 1, "no limit");
      chk(last_cmd.retries === 4'h3 && last_cmd.param === 8'hFF, "type b cmd");
      eop(1'b1);
   endtask

   task automatic s_rx_err();
      op(16'h2, 16'h8000, 16'h01, 16'h0400, 16'h3, 2'h1, 0);
      wresp();
      chk(transfer_error_flag === 1'b1 && wcnt === 2, "data error");
      eop(1'b1);
   endtask

   task automatic s_lim_def();
      op(16'h2, 16'h8000, 16'h02, 16'h0500, 16'h7, 2'h2, 0);
      repeat (70) @(posedge aclk);
      eop(1'b0);
      repeat (15) @(posedge aclk);
      eop(1'b1);
      chk(last_cmd.send === 1'b1 && last_cmd.src === 16'h0500 && wcnt === 0, "send");
   endtask

   task automatic s_checks();
      int n;
      logic x;
      for (int i = 0; i < 7; i++) begin
         unit_present <= (i != 6);
         wr(`NWTR_A_STAT, 32'h4);
         chk(instruction_error_flag === 1'b0, "error clear");
         setup(TV[i][0], TV[i][1], TV[i][2], TV[i][3], TV[i][4], TV[i][5]);
         n = cmd_seen;
         x = transfer_error_flag;
         wr(`NWTR_A_CTRL, {16'h0, TV[i][6]});
         repeat (3) @(posedge aclk);
         chk(instruction_error_flag === 1'b1 && cmd_seen === n, "check refused");
         chk(transfer_enable_flag === 1'b1 && transfer_error_flag === x, "flags kept");
      end
      unit_present <= 1'b1;
   endtask

   task automatic final_report();
      $display("comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, eop_pulse} = 6'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      unit_present = 1'b1;
      mode = 2'h0;
      lag = 0;
      {error_cnt, comparisons, wcnt, cmd_seen} = '0;
      exp_base = 16'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // sync flops on the unit pin need a few edges
      repeat (6) @(posedge aclk);
      s_reset();
      s_noexec();
      s_recv();
      s_tmo_a();
      s_lim_ff();
      s_rx_err();
      s_lim_def();
      s_checks();
      final_report();
   end

   initial begin
      #100000;
      error_cnt++;
      $display("wrong value at %0t: watchdog expired", $time);
      final_report();
   end
endmodule
